// File: hdl/smrd_consts.svh
`ifndef SMRD_CONSTS_SVH
`define SMRD_CONSTS_SVH
// mode register zero fields
`define SMRD_BL_LSB 0
`define SMRD_BT_BIT 3
`define SMRD_TM_BIT 7
`define SMRD_DLLRST_BIT 8
`define SMRD_WR_LSB 9
`define SMRD_WR_MSB 11
`define SMRD_PPD_BIT 12
// mode register one fields
`define SMRD_DLLDIS_BIT 0
`define SMRD_DIC0_BIT 1
`define SMRD_RTT0_BIT 2
`define SMRD_DIC1_BIT 5
`define SMRD_RTT1_BIT 6
`define SMRD_WLEV_BIT 7
`define SMRD_RTT2_BIT 9
`define SMRD_QOFF_BIT 12
// on-the-fly chop pin position within the address bus
`define SMRD_OTF_PIN 12
// register reset value and bank codes
`define SMRD_MR_RESET 16'h0000
`define SMRD_BA_MR0 3'h0
`define SMRD_BA_MR1 3'h1
// burst timing
`define SMRD_LAST_SLOT 3'h7
`define SMRD_CHOP_SLOTS 3'h4
`define SMRD_CHOP_PULL 2
`endif

// File: hdl/smrd_pkg.sv
`default_nettype none
package smrd_pkg;
  // burst length field encodings, in field order
  typedef enum logic [1:0] {
    SMRD_BL_FIX8,
    SMRD_BL_OTF,
    SMRD_BL_FIX4,
    SMRD_BL_RSVD
  } smrd_bl_t;
  // burst sequencer states
  typedef enum logic {
    SMRD_IDLE,
    SMRD_BURST
  } smrd_state_t;
endpackage : smrd_pkg
`default_nettype wire

// File: hdl/smrd_cmd_decode.sv
`timescale 1ns/100ps
`default_nettype none
`include "smrd_consts.svh"
module smrd_cmd_decode (
  input wire logic cs_n_i, // chip select
  input wire logic ras_n_i, // row strobe
  input wire logic cas_n_i, // column strobe
  input wire logic we_n_i, // write enable
  input wire logic [2:0] ba_i, // bank address
  output logic mrs0_o, // load mode_reg_zero
  output logic mrs1_o, // load mode_reg_one
  output logic rd_o, // read command
  output logic wr_o // write command
);
  logic mrs;
  // mode register set and column commands
  assign mrs = !cs_n_i && !ras_n_i && !cas_n_i && !we_n_i;
  assign mrs0_o = mrs && (ba_i == `SMRD_BA_MR0); // R23
  assign mrs1_o = mrs && (ba_i == `SMRD_BA_MR1); // R15
  assign rd_o = !cs_n_i && ras_n_i && !cas_n_i && we_n_i;
  assign wr_o = !cs_n_i && ras_n_i && !cas_n_i && !we_n_i;
endmodule : smrd_cmd_decode
`default_nettype wire

// File: hdl/smrd_beat_order.sv
`timescale 1ns/100ps
`default_nettype none
`include "smrd_consts.svh"
module smrd_beat_order (
  input wire logic [2:0] start_col_i, // starting column bits 2..0
  input wire logic interleave_i, // burst type
  input wire logic chop_i, // four-beat chop
  input wire logic write_i, // write burst
  input wire logic [2:0] slot_i, // beat slot 0..7
  output logic [2:0] beat_o, // column index of this slot
  output logic valid_o // slot carries data
);
  logic [1:0] low_seq;
  // wrapped low bits within the group of four
  assign low_seq = start_col_i[1:0] + slot_i[1:0];
  always_comb
  begin
    valid_o = 1'b1;
    if (write_i && !chop_i)
      beat_o = slot_i; // R7
    else if (write_i)
    begin
      beat_o = {start_col_i[2], slot_i[1:0]}; // R8
      valid_o = (slot_i < `SMRD_CHOP_SLOTS); // R8
    end
    else if (interleave_i)
      beat_o = start_col_i ^ slot_i; // R5
    else
      beat_o = {start_col_i[2] ^ slot_i[2], low_seq}; // R4
    if (!write_i && chop_i)
    begin
      beat_o[2] = start_col_i[2]; // R6
      valid_o = (slot_i < `SMRD_CHOP_SLOTS); // R6
    end
  end
endmodule : smrd_beat_order
`default_nettype wire

// File: hdl/smrd_mode_regs.sv
// Functional notes
// [R1] mode_reg_zero bit 7 set selects an unsupported test mode; normal is 0.
// [R2] mode_reg_zero A3 picks sequential (0) or interleaved (1) beat order.
// [R3] A1..A0 pick fixed chop, fixed eight, or per-command choice via A12.
// [R4] sequential eight-beat reads wrap within the starting group, then the other.
// [R5] interleaved eight-beat reads use beat count xor starting column bits.
// [R6] chop reads give four ordered beats, drivers off for the last four slots.
// [R7] eight-beat writes store beats 0..7 and ignore starting column bits.
// [R8] chop writes use column bit 2 for the group; last four slots ignored.
// [R9] fixed chop writes start write timing two cycles early; on-the-fly does not.
// [R10] the loop-reset bit clears itself after the reset is carried out.
// [R11] controller waits loop lock time after reset before reads or termination.
// [R12] A11..A9 hold write recovery cycles; controller programs at least the minimum.
// [R13] A12 at 0 freezes the loop in precharge power-down; slow exit.
// [R14] A12 at 1 keeps the loop running in precharge power-down; fast exit.
// [R15] command pins low with bank code 1 load mode_reg_one.
// [R16] write leveling with bit 12 at 0 allows only the three termination values.
// [R17] termination used during writes allows only the three termination values.
// [R18] enabled loop is turned off in self-refresh and back on at exit.
// [R19] controller holds clock enable high during loop lock time.
// [R20] loop-off mode requires nominal termination off by pin or zero bits.
// [R21] loop-off mode requires dynamic write termination off in mode_reg_two.
// [R22] mode_reg_one A1 and A5 select output driver impedance.
// [R23] command pins low with bank code 0 load mode_reg_zero.
// [R24] mode_reg_one A12 set disconnects all data and strobe drivers.
`timescale 1ns/100ps
`default_nettype none
`include "smrd_consts.svh"
module smrd_mode_regs #(
  parameter int ADDR_W = 16 // address pins
) (
  input wire logic clk_i, // command clock
  input wire logic reset_i, // synchronous reset, high
  input wire logic clk_en_i, // freezes all state when low
  input wire logic cs_n_i, // chip select, low active
  input wire logic ras_n_i, // row strobe, low active
  input wire logic cas_n_i, // column strobe, low active
  input wire logic we_n_i, // write enable, low active
  input wire logic [2:0] ba_i, // bank address
  input wire logic [ADDR_W-1:0] addr_i, // address pins
  input wire logic self_refresh_i, // device is in self-refresh
  input wire logic pre_pd_i, // device is in precharge power-down
  output logic [ADDR_W-1:0] mode_reg_zero_o, // stored mode_reg_zero
  output logic [ADDR_W-1:0] mode_reg_one_o, // stored mode_reg_one
  output logic test_mode_o, // unsupported test mode selected
  output logic interleave_o, // burst type interleaved
  output logic [1:0] burst_mode_o, // burst length selection
  output logic [2:0] wr_recovery_o, // write recovery code
  output logic loop_reset_o, // one-cycle loop reset pulse
  output logic loop_run_o, // delay loop running
  output logic [1:0] drv_imp_o, // output driver impedance code
  output logic [2:0] rtt_nom_o, // nominal termination code
  output logic wr_level_o, // write leveling mode
  output logic outputs_off_o, // data and strobe drivers disconnected
  output logic beat_valid_o, // a beat slot is presented
  output logic [2:0] beat_idx_o, // column index of the slot
  output logic dq_oe_o, // read data and strobe drivers on
  output logic wr_store_o, // write beat is stored
  output logic wr_pull_in_o // write timing starts two cycles early
);
  // elaboration check: the on-the-fly pin must lie within the address bus
  if (ADDR_W < 13)
  begin : g_addr_w_check
    $error("ADDR_W must cover the on-the-fly pin");
  end

  ////////////////////////////////////////////////////////////////////
  logic mrs0;
  logic mrs1;
  logic rd_cmd;
  logic wr_cmd;
  logic [ADDR_W-1:0] mr0;
  logic [ADDR_W-1:0] mr1;
  logic loop_rst_bit;
  smrd_pkg::smrd_state_t state;
  logic [2:0] slot;
  logic [2:0] start_col;
  logic burst_ilv;
  logic burst_chop;
  logic burst_wr;
  logic next_chop;
  logic [2:0] ord_beat;
  logic ord_valid;
  smrd_pkg::smrd_bl_t bl_mode;

  // command decode
  smrd_cmd_decode u_cmd (
    .cs_n_i(cs_n_i),
    .ras_n_i(ras_n_i),
    .cas_n_i(cas_n_i),
    .we_n_i(we_n_i),
    .ba_i(ba_i),
    .mrs0_o(mrs0),
    .mrs1_o(mrs1),
    .rd_o(rd_cmd),
    .wr_o(wr_cmd)
  );

  ////////////////////////////////////////////////////////////////////
  // mode register zero load
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      mr0 <= `SMRD_MR_RESET;
    else if (clk_en_i && mrs0)
      mr0 <= addr_i; // R23
  end

  // mode register one load
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      mr1 <= `SMRD_MR_RESET;
    else if (clk_en_i && mrs1)
      mr1 <= addr_i; // R15
  end

  // loop reset bit: a new write setting it wins over the self-clear
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      loop_rst_bit <= 1'b0;
    else if (clk_en_i)
    begin
      if (mrs0)
        loop_rst_bit <= addr_i[`SMRD_DLLRST_BIT];
      else if (loop_rst_bit)
        loop_rst_bit <= 1'b0; // R10
    end
  end

  ////////////////////////////////////////////////////////////////////
  // decoded fields
  assign bl_mode = smrd_pkg::smrd_bl_t'(mr0[`SMRD_BL_LSB +: 2]);
  assign mode_reg_zero_o = {mr0[ADDR_W-1:`SMRD_DLLRST_BIT+1], loop_rst_bit,
                            mr0[`SMRD_DLLRST_BIT-1:0]};
  assign mode_reg_one_o = mr1;
  assign test_mode_o = mr0[`SMRD_TM_BIT]; // R1
  assign interleave_o = mr0[`SMRD_BT_BIT]; // R2
  assign burst_mode_o = bl_mode; // R3
  assign wr_recovery_o = mr0[`SMRD_WR_MSB:`SMRD_WR_LSB]; // R12
  assign loop_reset_o = loop_rst_bit; // R10
  assign drv_imp_o = {mr1[`SMRD_DIC1_BIT], mr1[`SMRD_DIC0_BIT]}; // R22
  assign rtt_nom_o = {mr1[`SMRD_RTT2_BIT], mr1[`SMRD_RTT1_BIT], mr1[`SMRD_RTT0_BIT]};
  assign wr_level_o = mr1[`SMRD_WLEV_BIT];
  assign outputs_off_o = mr1[`SMRD_QOFF_BIT]; // R24

  // loop runs unless disabled, in self-refresh, or frozen in slow-exit power-down
  assign loop_run_o = !mr1[`SMRD_DLLDIS_BIT] && !self_refresh_i // R18
                      && !(pre_pd_i && !mr0[`SMRD_PPD_BIT]); // R13 R14

  ////////////////////////////////////////////////////////////////////
  // chop choice for a new column command
  always_comb
  begin
    case (bl_mode)
      smrd_pkg::SMRD_BL_FIX4: next_chop = 1'b1; // R3
      smrd_pkg::SMRD_BL_OTF: next_chop = !addr_i[`SMRD_OTF_PIN]; // R3
      default: next_chop = 1'b0;
    endcase
  end

  // burst sequencer, a new command restarts the slots
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state <= smrd_pkg::SMRD_IDLE;
      slot <= 3'h0;
    end
    else if (clk_en_i)
    begin
      case (state)
        smrd_pkg::SMRD_IDLE:
        begin
          slot <= 3'h0;
          if (rd_cmd || wr_cmd)
            state <= smrd_pkg::SMRD_BURST;
        end
        smrd_pkg::SMRD_BURST:
        begin
          if (rd_cmd || wr_cmd)
            slot <= 3'h0;
          else if (slot == `SMRD_LAST_SLOT)
          begin
            slot <= 3'h0;
            state <= smrd_pkg::SMRD_IDLE;
          end
          else
            slot <= slot + 3'h1;
        end
        default: state <= smrd_pkg::SMRD_IDLE;
      endcase
    end
  end

  // burst attributes captured with the command
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      start_col <= 3'h0;
      burst_ilv <= 1'b0;
      burst_chop <= 1'b0;
      burst_wr <= 1'b0;
      wr_pull_in_o <= 1'b0;
    end
    else if (clk_en_i && (rd_cmd || wr_cmd))
    begin
      start_col <= addr_i[2:0];
      burst_ilv <= mr0[`SMRD_BT_BIT]; // R2
      burst_chop <= next_chop;
      burst_wr <= wr_cmd;
      wr_pull_in_o <= wr_cmd && (bl_mode == smrd_pkg::SMRD_BL_FIX4); // R9
    end
  end

  // column ordering of the current slot
  smrd_beat_order u_order (
    .start_col_i(start_col),
    .interleave_i(burst_ilv),
    .chop_i(burst_chop),
    .write_i(burst_wr),
    .slot_i(slot),
    .beat_o(ord_beat),
    .valid_o(ord_valid)
  );

  // registered beat outputs
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      beat_valid_o <= 1'b0;
      beat_idx_o <= 3'h0;
      dq_oe_o <= 1'b0;
      wr_store_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      beat_valid_o <= (state == smrd_pkg::SMRD_BURST);
      beat_idx_o <= ord_beat;
      dq_oe_o <= (state == smrd_pkg::SMRD_BURST) && !burst_wr && ord_valid
                 && !mr1[`SMRD_QOFF_BIT]; // R6 R24
      wr_store_o <= (state == smrd_pkg::SMRD_BURST) && burst_wr && ord_valid; // R8
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  AST_MR0_LOAD: assert property (@(posedge clk_i) disable iff (reset_i) // R23
    clk_en_i && mrs0 |=> mr0 == $past(addr_i))
    else $error("mode_reg_zero not loaded");

  AST_MR1_LOAD: assert property (@(posedge clk_i) disable iff (reset_i) // R15
    clk_en_i && mrs1 |=> mr1 == $past(addr_i) && mr0 == $past(mr0))
    else $error("mode_reg_one load wrong");

  AST_TEST_MODE: assert property (@(posedge clk_i) disable iff (reset_i) // R1
    clk_en_i && mrs0 |=> test_mode_o == $past(addr_i[`SMRD_TM_BIT]))
    else $error("test mode bit wrong");

  AST_LOOP_CLEAR: assert property (@(posedge clk_i) disable iff (reset_i) // R10
    clk_en_i && mrs0 && addr_i[`SMRD_DLLRST_BIT] ##1 clk_en_i && !mrs0
    |=> !loop_reset_o)
    else $error("loop reset bit did not clear");

  AST_OTF_CHOP: assert property (@(posedge clk_i) disable iff (reset_i) // R3
    clk_en_i && rd_cmd && bl_mode == smrd_pkg::SMRD_BL_OTF
    |=> burst_chop == !$past(addr_i[`SMRD_OTF_PIN]))
    else $error("on-the-fly chop wrong");

  AST_SEQ8: assert property (@(posedge clk_i) disable iff (reset_i) // R4
    clk_en_i && state == smrd_pkg::SMRD_BURST && !burst_wr && !burst_chop && !burst_ilv
    |=> beat_idx_o == {$past(start_col[2] ^ slot[2]), $past(start_col[1:0] + slot[1:0])})
    else $error("sequential order wrong");

  AST_ILV8: assert property (@(posedge clk_i) disable iff (reset_i) // R5
    clk_en_i && state == smrd_pkg::SMRD_BURST && !burst_wr && !burst_chop && burst_ilv
    |=> beat_idx_o == $past(start_col ^ slot))
    else $error("interleaved order wrong");

  AST_CHOP_HIZ: assert property (@(posedge clk_i) disable iff (reset_i) // R6
    clk_en_i && state == smrd_pkg::SMRD_BURST && !burst_wr && burst_chop && slot[2]
    |=> !dq_oe_o)
    else $error("drivers on in chopped slot");

  AST_WR8: assert property (@(posedge clk_i) disable iff (reset_i) // R7
    clk_en_i && state == smrd_pkg::SMRD_BURST && burst_wr && !burst_chop
    |=> beat_idx_o == $past(slot) && wr_store_o)
    else $error("write order wrong");

  AST_CHOP_WR: assert property (@(posedge clk_i) disable iff (reset_i) // R8
    clk_en_i && state == smrd_pkg::SMRD_BURST && burst_wr && burst_chop
    |=> beat_idx_o[2] == $past(start_col[2]) && wr_store_o == !$past(slot[2]))
    else $error("chop write wrong");

  AST_PULL_IN: assert property (@(posedge clk_i) disable iff (reset_i) // R9
    clk_en_i && wr_cmd |=> wr_pull_in_o == ($past(bl_mode) == smrd_pkg::SMRD_BL_FIX4))
    else $error("write pull-in wrong");

  AST_LOOP_RUN: assert property (@(posedge clk_i) disable iff (reset_i) // R13
    pre_pd_i && !mr0[`SMRD_PPD_BIT] |-> !loop_run_o)
    else $error("loop not frozen in slow exit");

  AST_SELF_REF: assert property (@(posedge clk_i) disable iff (reset_i) // R18
    !mr1[`SMRD_DLLDIS_BIT] && !pre_pd_i |-> loop_run_o == !self_refresh_i)
    else $error("loop not tracking self-refresh");

  AST_QOFF: assert property (@(posedge clk_i) disable iff (reset_i) // R24
    outputs_off_o && clk_en_i && $stable(mr1) |=> !dq_oe_o)
    else $error("drivers on while outputs off");

  AST_BURST_LEN: assert property (@(posedge clk_i) disable iff (reset_i) // R4
    clk_en_i && state == smrd_pkg::SMRD_BURST && slot == `SMRD_LAST_SLOT
    && !rd_cmd && !wr_cmd |=> state == smrd_pkg::SMRD_IDLE)
    else $error("burst not ended after eight slots");

  AST_ILV_FLAG: assert property (@(posedge clk_i) disable iff (reset_i) // R2
    clk_en_i && mrs0 |=> interleave_o == $past(addr_i[`SMRD_BT_BIT]))
    else $error("burst type bit wrong");

  AST_WR_REC: assert property (@(posedge clk_i) disable iff (reset_i) // R12
    clk_en_i && mrs0
    |=> wr_recovery_o == $past(addr_i[`SMRD_WR_MSB:`SMRD_WR_LSB]))
    else $error("write recovery code wrong");

  AST_DRV_IMP: assert property (@(posedge clk_i) disable iff (reset_i) // R22
    clk_en_i && mrs1
    |=> drv_imp_o == {$past(addr_i[`SMRD_DIC1_BIT]), $past(addr_i[`SMRD_DIC0_BIT])})
    else $error("driver impedance code wrong");

  AST_FREEZE: assert property (@(posedge clk_i) disable iff (reset_i) // R15 R23
    !clk_en_i |=> mr0 == $past(mr0) && mr1 == $past(mr1) && slot == $past(slot))
    else $error("state moved with clock enable low");

  AST_FIX_CHOP: assert property (@(posedge clk_i) disable iff (reset_i) // R3
    clk_en_i && (rd_cmd || wr_cmd) && bl_mode == smrd_pkg::SMRD_BL_FIX4
    |=> burst_chop)
    else $error("fixed chop not applied");

  AST_LOOP_SET: assert property (@(posedge clk_i) disable iff (reset_i) // R10
    clk_en_i && mrs0 && addr_i[`SMRD_DLLRST_BIT] |=> loop_reset_o)
    else $error("loop reset bit not set");
endmodule : smrd_mode_regs
`default_nettype wire

// File: verif/smrd_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module smrd_ctrl_model (
  input wire logic clk_i, // command clock
  output logic cs_n_o, // chip select
  output logic ras_n_o, // row strobe
  output logic cas_n_o, // column strobe
  output logic we_n_o, // write enable
  output logic [2:0] ba_o, // bank address
  output logic [15:0] addr_o // address pins
);
  ////////////////////////////////////////////////////////////////
  // idle bus: deselected, nothing registered
  initial
  begin
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hf;
    ba_o = 3'h0;
    addr_o = 16'h0000;
  end
  // one command cycle; then deselect, with bank and address lines showing the inverse value
  task automatic issue(input logic [3:0] pins, input logic [2:0] ba, input logic [15:0] a);
    @(negedge clk_i);
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = pins;
    ba_o = ba;
    addr_o = a;
    @(negedge clk_i);
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hf;
    ba_o = ~ba;
    addr_o = ~a;
  endtask : issue
  // mode register load, bank code picks the register
  task automatic mrs(input logic [2:0] ba, input logic [15:0] a);
    issue(4'h0, ba, a);
  endtask : mrs
  // column commands, a12 carries the per-command length choice
  task automatic rd(input logic [15:0] a);
    issue(4'h5, 3'h0, a);
  endtask : rd
  task automatic wr(input logic [15:0] a);
    issue(4'h4, 3'h0, a);
  endtask : wr
endmodule : smrd_ctrl_model
`default_nettype wire

// File: verif/sdram_mode_reg_zero_one_decode_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module sdram_mode_reg_zero_one_decode_tb_top;
  logic clk_i, reset_i, clk_en_i, self_refresh_i, pre_pd_i;
  logic cs_n, ras_n, cas_n, we_n, test_mode, interleave, loop_reset, loop_run;
  logic wr_level, outputs_off, beat_valid, dq_oe, wr_store, wr_pull_in;
  logic [2:0] ba, wr_recovery, rtt_nom, beat_idx;
  logic [1:0] burst_mode, drv_imp;
  logic [15:0] addr, mr0, mr1;
  int n_errors = 0;
  int check_count = 0;
  localparam int LOCK_CYCLES = 32; // loop lock wait, plain default
  ////////////////////////////////////////////////////////////////
  // clock at 25 MHz
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  smrd_ctrl_model u_smrd_ctrl_model (.clk_i(clk_i), .cs_n_o(cs_n), .ras_n_o(ras_n),
    .cas_n_o(cas_n), .we_n_o(we_n), .ba_o(ba), .addr_o(addr));
  smrd_mode_regs #(.ADDR_W(16)) u_smrd_mode_regs (.clk_i(clk_i), .reset_i(reset_i),
    .clk_en_i(clk_en_i), .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n),
    .ba_i(ba), .addr_i(addr), .self_refresh_i(self_refresh_i), .pre_pd_i(pre_pd_i),
    .mode_reg_zero_o(mr0), .mode_reg_one_o(mr1), .test_mode_o(test_mode),
    .interleave_o(interleave), .burst_mode_o(burst_mode), .wr_recovery_o(wr_recovery),
    .loop_reset_o(loop_reset), .loop_run_o(loop_run), .drv_imp_o(drv_imp),
    .rtt_nom_o(rtt_nom), .wr_level_o(wr_level), .outputs_off_o(outputs_off),
    .beat_valid_o(beat_valid), .beat_idx_o(beat_idx), .dq_oe_o(dq_oe),
    .wr_store_o(wr_store), .wr_pull_in_o(wr_pull_in));
  ////////////////////////////////////////////////////////////////
  // value compare
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // verdict and end of run
  task automatic print_verdict();
    if (n_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////
  // mode_reg_zero fields, self-clearing loop reset, refused loads
  task automatic t_mr0();
    u_smrd_ctrl_model.mrs(3'h0, 16'h1b8a);
    chk(loop_reset, 1'b1);
    chk(test_mode, 1'b1);
    chk(interleave, 1'b1);
    chk(burst_mode, 2'h2);
    chk(wr_recovery, 3'h5);
    @(negedge clk_i);
    chk(loop_reset, 1'b0);
    chk(mr0, 16'h1a8a);
    repeat (LOCK_CYCLES) @(negedge clk_i);
    clk_en_i = 1'b0;
    u_smrd_ctrl_model.mrs(3'h0, 16'h0000);
    clk_en_i = 1'b1;
    u_smrd_ctrl_model.mrs(3'h2, 16'h0000);
    chk(mr0, 16'h1a8a);
    chk(mr1, 16'h0000);
  endtask : t_mr0
  // mode_reg_one fields
  task automatic t_mr1();
    u_smrd_ctrl_model.mrs(3'h1, 16'h12a4);
    chk(mr1, 16'h12a4);
    chk(drv_imp, 2'h2);
    chk(rtt_nom, 3'h5);
    chk(wr_level, 1'b1);
    chk(outputs_off, 1'b1);
    chk(mr0, 16'h1a8a);
    // a read while outputs are off keeps the drivers disconnected
    u_smrd_ctrl_model.mrs(3'h0, 16'h1000);
    u_smrd_ctrl_model.rd(16'h0000);
    @(negedge clk_i);
    chk(beat_valid, 1'b1);
    chk(dq_oe, 1'b0);
    // drivers back on and termination off before the read and write bursts that follow
    u_smrd_ctrl_model.mrs(3'h1, 16'h0000);
    repeat (8) @(negedge clk_i);
    chk(outputs_off, 1'b0);
    chk(beat_valid, 1'b0);
  endtask : t_mr1
  // delay loop state against power modes
  task automatic t_loop();
    pre_pd_i = 1'b1;
    #5 chk(loop_run, 1'b1);
    u_smrd_ctrl_model.mrs(3'h0, 16'h0000);
    #5 chk(loop_run, 1'b0);
    @(negedge clk_i);
    pre_pd_i = 1'b0;
    self_refresh_i = 1'b1;
    #5 chk(loop_run, 1'b0);
    @(negedge clk_i);
    self_refresh_i = 1'b0;
    #5 chk(loop_run, 1'b1);
    u_smrd_ctrl_model.mrs(3'h1, 16'h0001);
    #5 chk(loop_run, 1'b0);
    u_smrd_ctrl_model.mrs(3'h2, 16'h0000);
    chk(mr1, 16'h0001);
  endtask : t_loop
  // one column burst with beat order, drivers and stores per slot
  task automatic t_burst(input logic w, input logic [1:0] bl, input logic bt,
    input logic [2:0] s, input logic otf);
    logic chop;
    logic live;
    logic [2:0] k;
    logic [2:0] exp;
    chop = (bl == 2'h2) || (bl == 2'h1 && !otf);
    u_smrd_ctrl_model.mrs(3'h0, 16'h1200 | {12'h000, bt, 1'b0, bl});
    if (w)
      u_smrd_ctrl_model.wr({3'h0, otf, 9'h000, s});
    else
      u_smrd_ctrl_model.rd({3'h0, otf, 9'h000, s});
    chk(wr_pull_in, w && bl == 2'h2);
    for (int i = 0; i < 8; i++)
    begin
      k = 3'(i);
      live = !chop || i < 4;
      if (w)
        exp = chop ? {s[2], k[1:0]} : k;
      else if (bt)
        exp = s ^ k;
      else
        exp = {s[2] ^ k[2], s[1:0] + k[1:0]};
      @(negedge clk_i);
      chk(beat_valid, 1'b1);
      chk(dq_oe, !w && live);
      chk(wr_store, w && live);
      if (live)
        chk(beat_idx, exp);
    end
    @(negedge clk_i);
    chk(beat_valid, 1'b0);
  endtask : t_burst
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    reset_i = 1'b1;
    clk_en_i = 1'b1;
    self_refresh_i = 1'b0;
    pre_pd_i = 1'b0;
    repeat (16) @(negedge clk_i);
    chk(mr0, 16'h0000);
    chk(beat_valid, 1'b0);
    chk(loop_run, 1'b1);
    reset_i = 1'b0;
    t_mr0();
    t_mr1();
    for (int i = 0; i < 8; i++)
    begin
      t_burst(1'b0, 2'h0, 1'b0, 3'(i), 1'b1);
      t_burst(1'b0, 2'h0, 1'b1, 3'(i), 1'b1);
      t_burst(1'b0, 2'h2, 3'(i) > 3, 3'(i), 1'b1);
      t_burst(1'b1, 2'h0, 1'b1, 3'(i), 1'b1);
      t_burst(1'b1, 2'h2, 1'b0, 3'(i), 1'b0);
    end
    t_burst(1'b1, 2'h1, 1'b0, 3'h6, 1'b0);
    t_burst(1'b0, 2'h1, 1'b0, 3'h5, 1'b1);
    t_burst(1'b0, 2'h1, 1'b1, 3'h3, 1'b0);
    t_burst(1'b0, 2'h3, 1'b0, 3'h2, 1'b0);
    t_loop();
    print_verdict();
  end
  // watchdog against a hung run
  initial
  begin
    #2000000;
    n_errors++;
    print_verdict();
  end
endmodule : sdram_mode_reg_zero_one_decode_tb_top
`default_nettype wire
